// File: design/acs_conv_if.sv
// handshake between the sequencer and its converter timer
`default_nettype none
interface acs_conv_if;
	logic start;
	logic [acs_pkg::SMP_BITS-1:0] sample_len;
	logic tick;
	logic sampling;
	logic done;
	modport seq (output start, output sample_len, input tick, input sampling, input done);
	modport tmr (input start, input sample_len, output tick, output sampling, output done);
endinterface
`default_nettype wire

// File: design/acs_conv_timer.sv
// converter clock divider and sample/convert slot timer
`default_nettype none
module acs_conv_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	acs_conv_if.tmr cv
);
	typedef struct packed {
		logic [acs_pkg::DIV_BITS-1:0] div;
		logic [acs_pkg::SMP_BITS-1:0] smp;
		logic [acs_pkg::CNT_BITS-1:0] cnt;
		logic sampling;
		logic converting;
		logic done;
	} acs_tmr_t;
	acs_tmr_t s;
	acs_tmr_t next_s;
	logic tick;

	// refuse constants the divider or slot counter cannot hold
	if (acs_pkg::CONV_DIV > (1 << acs_pkg::DIV_BITS)) begin
		$error("divider too wide");
	end
	if (acs_pkg::CONV_CYCLES > (1 << acs_pkg::CNT_BITS)) begin
		$error("conversion counter too narrow");
	end

	assign tick = run && (s.div == acs_pkg::DIV_LAST);
	assign cv.tick = tick;
	assign cv.sampling = s.sampling;
	assign cv.done = s.done;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (!run) begin
			next_s = '0;
		end else begin
			// converter clock stays at or below its maximum rate
			next_s.div = tick ? '0 : s.div + 1'b1;
			if (cv.start && !s.sampling && !s.converting) begin
				next_s.sampling = 1'b1;
				next_s.smp = cv.sample_len;
			end else if (tick && s.sampling) begin
				if (s.smp <= 1) begin
					next_s.sampling = 1'b0;
					next_s.converting = 1'b1;
					next_s.cnt = '0;
				end else begin
					next_s.smp = s.smp - 1'b1;
				end
			end else if (tick && s.converting) begin
				if (s.cnt == acs_pkg::CONV_LAST) begin
					next_s.converting = 1'b0;
					next_s.done = 1'b1;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end
endmodule
`default_nettype wire

// File: design/acs_pkg.sv
// constants and types shared by the converter sequencer
`default_nettype none
package acs_pkg;
	localparam int unsigned CHANNELS = 8;
	localparam int unsigned RES_BITS = 12;
	localparam int unsigned CH_BITS = 3;
	localparam int unsigned SMP_BITS = 8;
	localparam int unsigned CONV_CLK_MHZ_MAX = 18;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CONV_CYCLES = 18;
	localparam int unsigned CONV_DIV = (CLK_MHZ + CONV_CLK_MHZ_MAX - 1) / CONV_CLK_MHZ_MAX;
	localparam int unsigned DIV_BITS = 4;
	localparam int unsigned CNT_BITS = 5;
	localparam logic [DIV_BITS-1:0] DIV_LAST = DIV_BITS'(CONV_DIV - 1);
	localparam logic [CNT_BITS-1:0] CONV_LAST = CNT_BITS'(CONV_CYCLES - 1);
	localparam logic [SMP_BITS-1:0] SMP_RESET = 8'h03;
	localparam logic [RES_BITS-1:0] LIMIT_LOW_RESET = 12'h000;
	localparam logic [RES_BITS-1:0] LIMIT_HIGH_RESET = 12'hFFF;
	typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_state_t;
endpackage
`default_nettype wire

// File: design/acs_sequencer.sv
// eight-input converter channel sequencer with limit check
// How it works
// - converter clock capped, eighteen clocks per conversion
// - sample window length is programmable
// - scans enabled channels of eight autonomously
// - next channel starts without idle slot
// - firmware or scanner selects the channel
// - one result buffer per channel
// - per-channel sample time applied
// - low/high limits raise out-of-range flag
// - range checked on each fresh result
// - stops in deepest low-power mode
// - deep sleep stops the converter clock and abandons the conversion in progress
`default_nettype none
module acs_sequencer #(
	parameter int unsigned CHANNELS = acs_pkg::CHANNELS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic deep_sleep,
	input wire logic fw_select,
	input wire logic [acs_pkg::CH_BITS-1:0] fw_channel,
	input wire logic fw_start,
	input wire logic [CHANNELS-1:0] chan_enable,
	input wire logic [CHANNELS*acs_pkg::SMP_BITS-1:0] sample_time,
	input wire logic [acs_pkg::RES_BITS-1:0] limit_low,
	input wire logic [acs_pkg::RES_BITS-1:0] limit_high,
	input wire logic range_clear,
	input wire logic [acs_pkg::CH_BITS-1:0] read_channel,
	input wire logic [acs_pkg::RES_BITS-1:0] core_result,
	output logic [acs_pkg::CH_BITS-1:0] mux_channel,
	output logic core_sample,
	output logic core_tick,
	output logic [acs_pkg::RES_BITS-1:0] read_data,
	output logic [CHANNELS-1:0] result_valid,
	output logic result_strobe,
	output logic [acs_pkg::CH_BITS-1:0] result_channel,
	output logic scan_done,
	output logic out_of_range,
	output logic busy
);
	typedef struct packed {
		acs_pkg::acs_state_t state;
		logic [acs_pkg::CH_BITS-1:0] chan;
		logic [CHANNELS-1:0] valid;
		logic [acs_pkg::RES_BITS-1:0] rdata;
		logic strobe;
		logic [acs_pkg::CH_BITS-1:0] rchan;
		logic sdone;
		logic oor;
	} acs_seq_t;
	acs_seq_t s;
	acs_seq_t next_s;
	logic [acs_pkg::RES_BITS-1:0] results [CHANNELS];
	logic run;
	logic start;
	logic [acs_pkg::CH_BITS-1:0] next_ch;
	logic wrapped;
	logic in_range;

	acs_conv_if cv ();

	// refuse channel counts the select field cannot address
	if (CHANNELS < 1 || CHANNELS > (1 << acs_pkg::CH_BITS)) begin
		$error("channel count not supported");
	end

	// next enabled channel after cur, with wrap indication
	function automatic logic [acs_pkg::CH_BITS:0] next_enabled(
		input logic [acs_pkg::CH_BITS-1:0] cur,
		input logic [CHANNELS-1:0] en
	);
		logic [acs_pkg::CH_BITS:0] r;
		logic found;
		int unsigned idx;
		r = {1'b1, cur};
		found = 1'b0;
		for (int unsigned k = 1; k <= CHANNELS; k++) begin
			idx = (int'(cur) + k) % CHANNELS;
			if (!found && en[idx]) begin
				found = 1'b1;
				r = {(idx <= int'(cur)), acs_pkg::CH_BITS'(idx)};
			end
		end
		return r;
	endfunction

	function automatic logic [acs_pkg::SMP_BITS-1:0] smp_of(
		input logic [acs_pkg::CH_BITS-1:0] ch,
		input logic [CHANNELS*acs_pkg::SMP_BITS-1:0] st
	);
		return st[ch*acs_pkg::SMP_BITS +: acs_pkg::SMP_BITS];
	endfunction

	assign run = enable && !deep_sleep;
	assign {wrapped, next_ch} = next_enabled(s.chan, chan_enable);
	assign in_range = (core_result >= limit_low) && (core_result <= limit_high);

	// a new sample is requested from the sample state, the cycle after the last one completes
	always_comb begin
		start = 1'b0;
		if (run && s.state != acs_pkg::ACS_IDLE && (s.state == acs_pkg::ACS_SAMPLE))
			start = 1'b1;
	end

	assign cv.start = start;
	assign cv.sample_len = smp_of(s.chan, sample_time);

	acs_conv_timer u_timer (
		.clk(clk),
		.rst(rst),
		.run(run),
		.cv(cv)
	);

	assign mux_channel = s.chan;
	assign core_sample = cv.sampling;
	assign core_tick = cv.tick;
	assign read_data = s.rdata;
	assign result_valid = s.valid;
	assign result_strobe = s.strobe;
	assign result_channel = s.rchan;
	assign scan_done = s.sdone;
	assign out_of_range = s.oor;
	assign busy = (s.state != acs_pkg::ACS_IDLE);

	always_comb begin
		next_s = s;
		next_s.strobe = 1'b0;
		next_s.sdone = 1'b0;
		next_s.rdata = results[read_channel];
		if (range_clear)
			next_s.oor = 1'b0;
		case (s.state)
			acs_pkg::ACS_IDLE: begin
				if (run && fw_select && fw_start) begin
					next_s.chan = fw_channel;
					next_s.state = acs_pkg::ACS_SAMPLE;
				end else if (run && !fw_select && |chan_enable) begin
					next_s.chan = chan_enable[s.chan] ? s.chan : next_ch;
					next_s.state = acs_pkg::ACS_SAMPLE;
				end
			end
			acs_pkg::ACS_SAMPLE: begin
				next_s.state = acs_pkg::ACS_CONVERT;
			end
			acs_pkg::ACS_CONVERT: begin
				// a result finishing as the clock drops is discarded
				if (run && cv.done) begin
					next_s.valid[s.chan] = 1'b1;
					next_s.strobe = 1'b1;
					next_s.rchan = s.chan;
					if (!in_range)
						next_s.oor = 1'b1;
					if (!fw_select && |chan_enable) begin
						next_s.chan = next_ch;
						next_s.sdone = wrapped;
						next_s.state = acs_pkg::ACS_SAMPLE;
					end else begin
						next_s.sdone = 1'b1;
						next_s.state = acs_pkg::ACS_IDLE;
					end
				end
			end
			default: next_s.state = acs_pkg::ACS_IDLE;
		endcase
		if (!run)
			next_s.state = acs_pkg::ACS_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// per-channel buffer keeps newest result
	always_ff @(posedge clk) begin
		if (s.state == acs_pkg::ACS_CONVERT && cv.done && run)
			results[s.chan] <= core_result;
	end
endmodule
`default_nettype wire

// File: test/acs_core_model.sv
// behavioural converter core, result encodes the sampled channel
`default_nettype none
module acs_core_model (
	input wire logic clk,
	input wire logic core_sample,
	input wire logic [2:0] mux_channel,
	output logic [11:0] core_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] held;
	always_ff @(posedge clk) begin
		if (core_sample) begin
			held <= mux_channel;
		end
	end
	// unsettled pattern while the window is open
	assign core_result = core_sample ? 12'h5A5 : {held, 9'h100};
endmodule
`default_nettype wire

// File: test/acs_sequencer_asserts.sv
// assertions for the converter channel sequencer
`default_nettype none
module acs_sequencer_asserts #(parameter int unsigned CHANNELS = 8) (
	input wire logic clk,
	input wire logic rst,
	input wire logic deep_sleep,
	input wire logic range_clear,
	input wire logic core_sample,
	input wire logic core_tick,
	input wire logic [CHANNELS-1:0] result_valid,
	input wire logic result_strobe,
	input wire logic [2:0] result_channel,
	input wire logic out_of_range,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ticks;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// converter ticks since the sample window closed
	always_ff @(posedge clk) begin
		if (rst || core_sample) begin
			ticks <= 8'h00;
		end else if (core_tick) begin
			ticks <= ticks + 8'h01;
		end
	end
	a_tick_spacing: assert property (core_tick |=> !core_tick [*5])
		else $error("tick spacing");
	a_conv_length: assert property (result_strobe |-> ticks + {7'h00, core_tick} >= 8'h12)
		else $error("conversion too short");
	a_strobe_single: assert property (result_strobe |=> !result_strobe)
		else $error("strobe too long");
	a_valid_marked: assert property (result_strobe |=> result_valid[$past(result_channel)])
		else $error("valid bit missing");
	a_flag_sticky: assert property (out_of_range && !range_clear |=> out_of_range)
		else $error("flag dropped");
	a_flag_cause: assert property ($rose(out_of_range) |-> result_strobe || $past(result_strobe))
		else $error("flag without result");
	a_sleep_idle: assert property (deep_sleep [*2] |-> !busy && !core_sample)
		else $error("active in sleep");
	a_sleep_silent: assert property ($past(deep_sleep) |-> !result_strobe)
		else $error("result in sleep");
	c_result: cover property (result_strobe);
	c_flag: cover property ($rose(out_of_range));
	c_sleep: cover property (deep_sleep && busy);
endmodule
bind acs_sequencer acs_sequencer_asserts #(.CHANNELS(CHANNELS)) chk_u (
	.clk(clk),
	.rst(rst),
	.deep_sleep(deep_sleep),
	.range_clear(range_clear),
	.core_sample(core_sample),
	.core_tick(core_tick),
	.result_valid(result_valid),
	.result_strobe(result_strobe),
	.result_channel(result_channel),
	.out_of_range(out_of_range),
	.busy(busy)
);
`default_nettype wire

// File: test/acs_sequencer_tb.sv
// self-checking bench for the converter channel sequencer
`default_nettype none
module acs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, enable = 1'h0, deep_sleep = 1'h0, fw_select = 1'h1;
	logic fw_start = 1'h0, range_clear = 1'h0, core_sample, core_tick, result_strobe;
	logic scan_done, out_of_range, busy;
	logic [2:0] fw_channel = 3'h0, read_channel = 3'h0, mux_channel, result_channel;
	logic [7:0] chan_enable = 8'h83, result_valid;
	logic [63:0] sample_time = {8{8'h03}};
	logic [11:0] limit_low = 12'h300, limit_high = 12'hBFF, core_result, read_data;
	int err_count = 0, checks = 0, l3, l10, gap;
	acs_sequencer dut_u (
		.clk(clk),
		.rst(rst),
		.enable(enable),
		.deep_sleep(deep_sleep),
		.fw_select(fw_select),
		.fw_channel(fw_channel),
		.fw_start(fw_start),
		.chan_enable(chan_enable),
		.sample_time(sample_time),
		.limit_low(limit_low),
		.limit_high(limit_high),
		.range_clear(range_clear),
		.read_channel(read_channel),
		.core_result(core_result),
		.mux_channel(mux_channel),
		.core_sample(core_sample),
		.core_tick(core_tick),
		.read_data(read_data),
		.result_valid(result_valid),
		.result_strobe(result_strobe),
		.result_channel(result_channel),
		.scan_done(scan_done),
		.out_of_range(out_of_range),
		.busy(busy)
	);
	acs_core_model core_u (
		.clk(clk),
		.core_sample(core_sample),
		.mux_channel(mux_channel),
		.core_result(core_result)
	);
	always #5 clk = ~clk;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wait_hi(input int done, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((done ? scan_done : result_strobe) !== 1'h1 && n < 3000);
		if (n >= 3000) err_count++;
	endtask
	task automatic start_fw(input logic [2:0] ch);
		@(posedge clk);
		fw_channel <= ch;
		fw_start <= 1'h1;
		@(posedge clk);
		fw_start <= 1'h0;
	endtask
	task automatic fw_conv(input logic [2:0] ch, output int n);
		start_fw(ch);
		wait_hi(0, n);
		repeat (4) @(posedge clk);
	endtask
	task automatic read_chk(input logic [2:0] ch, input logic [11:0] exp);
		@(posedge clk);
		read_channel <= ch;
		repeat (2) @(negedge clk);
		check(read_data, exp, "read_data");
	endtask
	task automatic t_fw();
		@(posedge clk);
		enable <= 1'h1;
		fw_conv(3'h6, l3);
		read_chk(3'h6, 12'hD00);
		check(out_of_range, 1'h1, "out_of_range");
		@(posedge clk);
		sample_time[55:48] <= 8'h0A;
		fw_conv(3'h6, l10);
		check((l10 - l3) inside {[37:47]}, 1'h1, "sample_len");
		range_clear <= 1'h1;
		@(posedge clk);
		range_clear <= 1'h0;
		fw_conv(3'h1, l10);
		read_chk(3'h1, 12'h300);
		check(out_of_range, 1'h0, "out_of_range");
		fw_conv(3'h0, l10);
		fw_conv(3'h1, l10);
		check(out_of_range, 1'h1, "out_of_range");
	endtask
	task automatic t_sleep();
		start_fw(3'h6);
		repeat (40) @(posedge clk);
		deep_sleep <= 1'h1;
		repeat (200) @(negedge clk);
		check(busy, 1'h0, "busy");
		@(posedge clk);
		deep_sleep <= 1'h0;
		repeat (300) @(negedge clk);
		check(busy, 1'h0, "busy");
	endtask
	task automatic t_scan();
		@(posedge clk);
		fw_select <= 1'h0;
		wait_hi(0, gap);
		check(result_channel, 3'h7, "result_channel");
		check(scan_done, 1'h1, "scan_done");
		wait_hi(0, gap);
		check(result_channel, 3'h0, "result_channel");
		check(scan_done, 1'h0, "scan_done");
		check(gap <= l3 + 5, 1'h1, "handoff");
		wait_hi(1, gap);
		wait_hi(1, gap);
		check(result_valid, 8'hC3, "result_valid");
		read_chk(3'h0, 12'h100);
		read_chk(3'h7, 12'hF00);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		check(result_valid, 8'h00, "result_valid");
		t_fw();
		t_sleep();
		t_scan();
		conclude();
	end
	initial begin
		#100000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
